// ===== osc_ctrl_reg.sv
// APB slave holding the oscillator control register and its output stage.
// Assumes an APB master on pclk and an overflow pulse from an accumulator on pclk.
//
// Function
// - The oscillator runs only while the enable bit 7 is one and is disabled while it is zero.
// - Bit 5 is read only and returns the level the oscillator is driving at that moment.
// - When polarity bit 4 is one the oscillator output is inverted, otherwise it passes as is.
// - Bit 0 selects pulse-frequency output at one and divide-by-two fixed duty at zero.
// - Bit 6 and bits 3 to 1 always read as zero.
// - Every implemented bit is cleared to zero on every reset.
`timescale 1ns/1ps
`include "osc_defines.svh"

module osc_ctrl_reg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`OSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic overflow,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic osc_out,
  output logic osc_run
);

  // Register state.
  osc_pkg::ctrl_byte_t ctrl_q;
  osc_pkg::ctrl_byte_t ctrl_d;

  // Bus answer state.
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Enable copy driven out to the accumulator.
  logic run_q;
  logic run_d;

  // Decode.
  logic access;
  logic hit_ctrl;
  logic wr_ctrl;
  logic rd_first;
  logic out_level;
  osc_pkg::ctrl_byte_t ctrl_view;
  osc_pkg::out_mode_t mode;

  // Every access gets exactly one wait state: pready is registered so that it
  // leaves a flop, at the cost of one cycle per transfer.
  assign access = psel && penable;
  assign hit_ctrl = (paddr == `OSC_CTRL_ADDR);
  assign rd_first = access && !pready_q;
  assign wr_ctrl = access && pready_q && pwrite && hit_ctrl && pstrb[0];

  assign mode = ctrl_q[`OSC_PFM_BIT] ? osc_pkg::MODE_PULSE_FREQ : osc_pkg::MODE_FIXED_DUTY;

  osc_output_stage u_stage (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl_q[`OSC_EN_BIT]),
    .mode(mode),
    .invert(ctrl_q[`OSC_INV_BIT]),
    .overflow(overflow),
    .out_q(out_level)
  );

  // Read view of the control register.
  always_comb begin
    ctrl_view = ctrl_q & `OSC_CTRL_WMASK;
    ctrl_view[`OSC_OUT_BIT] = out_level;
  end

  // Control register next value.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = (ctrl_q & ~`OSC_CTRL_WMASK) | (pwdata[7:0] & `OSC_CTRL_WMASK);
    end
    run_d = ctrl_d[`OSC_EN_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `OSC_CTRL_RESET;
      run_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      run_q <= run_d;
    end
  end

  // Bus answer next values.
  always_comb begin
    pready_d = rd_first;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (rd_first) begin
      // Unmapped addresses answer with an error and zero data; writes to them are dropped.
      pslverr_d = !hit_ctrl;
      if (!pwrite && hit_ctrl) begin
        prdata_d = {24'h00_0000, ctrl_view};
      end else begin
        prdata_d = `OSC_RDATA_NONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `OSC_RDATA_NONE;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign osc_out = out_level;
  assign osc_run = run_q;

  // Checks.

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_first_access;
    psel && penable && !pready_q;
  endsequence

  sequence s_ctrl_read;
    s_first_access ##0 (!pwrite && hit_ctrl);
  endsequence

  chk_ready_one_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_first_access |=> pready_q ##1 !pready_q
  ) else $error("pready did not follow the one wait state timing");

  chk_disabled_parks: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_q[`OSC_EN_BIT] && !wr_ctrl) [*2] |=> (osc_out == $past(ctrl_q[`OSC_INV_BIT]))
  ) else $error("disabled oscillator output is not at its idle level");

  chk_run_follows_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 (osc_run == $past(pwdata[`OSC_EN_BIT], 2))
  ) else $error("enable output does not follow the written enable bit");

  chk_view_reads_out: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read |=> (prdata[`OSC_OUT_BIT] == $past(out_level))
  ) else $error("read of bit 5 does not show the driven output level");

  chk_pulse_inverted: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[`OSC_EN_BIT] && ctrl_q[`OSC_PFM_BIT] && overflow && !wr_ctrl)
      |=> (osc_out == !$past(ctrl_q[`OSC_INV_BIT]))
  ) else $error("pulse level does not respect the polarity bit");

  chk_pulse_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[`OSC_EN_BIT] && ctrl_q[`OSC_PFM_BIT] && !overflow && !wr_ctrl)
      |=> (osc_out == $past(ctrl_q[`OSC_INV_BIT]))
  ) else $error("pulse mode output is active without an overflow");

  chk_fixed_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[`OSC_EN_BIT] && !ctrl_q[`OSC_PFM_BIT] && !wr_ctrl) [*2]
      ##0 overflow |=> (osc_out != $past(osc_out))
  ) else $error("fixed duty output did not toggle on overflow");

  chk_fixed_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[`OSC_EN_BIT] && !ctrl_q[`OSC_PFM_BIT] && !wr_ctrl) [*2]
      ##0 !overflow |=> $stable(osc_out)
  ) else $error("fixed duty output changed without an overflow");

  chk_zero_bits: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready_q |-> ((prdata[7:0] & `OSC_CTRL_ZMASK) == 8'h00) && (prdata[31:8] == 24'h00_0000)
  ) else $error("unimplemented bits read as nonzero");

  chk_reset_clear: assert property (
    @(posedge pclk)
    $rose(presetn) |-> (ctrl_q == `OSC_CTRL_RESET) && !osc_out && !osc_run && !pready
  ) else $error("control state not cleared by reset");

  chk_write_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> (ctrl_q == ($past(pwdata[7:0]) & `OSC_CTRL_WMASK))
  ) else $error("write did not update exactly the writable bits");

  chk_hold_no_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(ctrl_q)
  ) else $error("control register changed without a write");

  chk_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_first_access ##0 !hit_ctrl |=> pready && pslverr && (prdata == `OSC_RDATA_NONE)
  ) else $error("unmapped access did not answer with an error");

  // Bus answer and refusal checks.

  sequence s_ctrl_write_done;
    psel && penable && pready_q && pwrite && hit_ctrl;
  endsequence

  sequence s_stray_write_done;
    psel && penable && pready_q && pwrite && !hit_ctrl;
  endsequence

  chk_ready_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready
  ) else $error("pready stayed high for more than one cycle");

  chk_ready_needs_access: assert property (
    @(posedge pclk) disable iff (!presetn)
    !access |=> !pready
  ) else $error("pready rose without an access cycle");

  chk_err_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready
  ) else $error("pslverr raised outside the completion cycle");

  chk_ctrl_no_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_first_access ##0 hit_ctrl |=> pready && !pslverr
  ) else $error("access to the control register answered with an error");

  chk_strobe_off_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_write_done ##0 !pstrb[0] |=> $stable(ctrl_q)
  ) else $error("write with its low byte strobe off changed the register");

  chk_stray_write_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_stray_write_done |=> $stable(ctrl_q)
  ) else $error("write to an unmapped address changed the register");

  chk_read_no_change: assert property (
    @(posedge pclk) disable iff (!presetn)
    access && !pwrite |=> $stable(ctrl_q)
  ) else $error("read access changed the register");

  chk_stored_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q & ~`OSC_CTRL_WMASK) == 8'h00
  ) else $error("a read only or unimplemented bit is stored as one");

  // Read-back and oscillator checks.

  sequence s_fixed_steady;
    ctrl_q[`OSC_EN_BIT] && !ctrl_q[`OSC_PFM_BIT] && !wr_ctrl;
  endsequence

  sequence s_parked;
    !ctrl_q[`OSC_EN_BIT] && !wr_ctrl;
  endsequence

  chk_read_enable: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read |=> (prdata[`OSC_EN_BIT] == $past(ctrl_q[`OSC_EN_BIT]))
  ) else $error("read of bit 7 does not show the enable");

  chk_read_invert: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read |=> (prdata[`OSC_INV_BIT] == $past(ctrl_q[`OSC_INV_BIT]))
  ) else $error("read of bit 4 does not show the polarity");

  chk_read_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_read |=> (prdata[`OSC_PFM_BIT] == $past(ctrl_q[`OSC_PFM_BIT]))
  ) else $error("read of bit 0 does not show the output mode");

  chk_run_is_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    osc_run == ctrl_q[`OSC_EN_BIT]
  ) else $error("run output disagrees with the enable bit");

  chk_parked_ignores_ovf: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_parked [*2] ##0 overflow |=> $stable(osc_out)
  ) else $error("disabled oscillator reacted to an overflow");

  // A disable must clear the divide-by-two phase, or a re-enabled output could start high.
  chk_restart_from_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_parked ##1 wr_ctrl ##1 (s_fixed_steady ##0 !overflow)
      |=> (osc_out == $past(ctrl_q[`OSC_INV_BIT]))
  ) else $error("fixed duty output did not restart low after a disable");

endmodule

// ===== osc_defines.svh
// Named constants for the oscillator control register block.
// Assumes it is included by bare name from each design file that needs it.
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// APB address width and the byte address of the control register.
`define OSC_ADDR_W 12
`define OSC_CTRL_ADDR 12'h000

// Field positions inside oscillator_control.
`define OSC_EN_BIT 7
`define OSC_OUT_BIT 5
`define OSC_INV_BIT 4
`define OSC_PFM_BIT 0

// Bits that software may write, bits that read as zero, and the reset value.
`define OSC_CTRL_WMASK 8'h91
`define OSC_CTRL_ZMASK 8'h4e
`define OSC_CTRL_RESET 8'h00

// Read data returned for an unmapped address.
`define OSC_RDATA_NONE 32'h0000_0000

`endif

// ===== osc_output_stage.sv
// Output stage of the oscillator: turns accumulator overflow pulses into the output level.
// Assumes the overflow pulse is one cycle long and comes from logic on the same clock.
`timescale 1ns/1ps
`include "osc_defines.svh"

module osc_output_stage (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire osc_pkg::out_mode_t mode,
  input wire logic invert,
  input wire logic overflow,
  output logic out_q
);

  logic raw_q;
  logic raw_d;
  logic out_d;

  always_comb begin
    raw_d = raw_q;
    if (!enable) begin
      // A disabled oscillator parks its phase low, so the output rests at the polarity level and restarts from a known phase.
      raw_d = 1'b0;
    end else begin
      case (mode)
        osc_pkg::MODE_PULSE_FREQ: raw_d = overflow;
        osc_pkg::MODE_FIXED_DUTY: raw_d = overflow ? ~raw_q : raw_q;
        default: raw_d = 1'b0;
      endcase
    end
    out_d = raw_d ^ invert;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      raw_q <= raw_d;
      out_q <= out_d;
    end
  end

endmodule

// ===== osc_pkg.sv
// Types shared by the oscillator control register and its output stage.
// Assumes nothing of its surroundings; it is compiled first.
package osc_pkg;

  typedef logic [7:0] ctrl_byte_t;

  typedef enum logic {
    MODE_FIXED_DUTY,
    MODE_PULSE_FREQ
  } out_mode_t;

endpackage

// ===== tb_nco_control_register.sv
// Self-checking testbench for the oscillator control register and its output stage.
// Assumes osc_defines.svh, osc_pkg and the design files are compiled before it.
`timescale 1ns/1ps
`include "osc_defines.svh"

module tb_nco_control_register;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, overflow, osc_out, osc_run;
  logic [`OSC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic err;
  int num_errors, checks_done;

  osc_ctrl_reg u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .overflow(overflow),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_out(osc_out),
    .osc_run(osc_run));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic results();
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Values seen right after an edge are the ones the edge sampled, so the
  // request is released only after pready was seen high there.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      input logic [3:0] sb);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= sb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: no pready", $time);
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(2);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_err);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, exp, "read data");
    chk({31'h0, err}, {31'h0, e_err}, "read error");
  endtask

  // One overflow pulse, then the output level in each of the two cycles after it.
  task automatic pulse(input logic e1, input logic e2);
    overflow <= 1'b1;
    @(posedge pclk);
    overflow <= 1'b0;
    @(posedge pclk);
    chk({31'h0, osc_out}, {31'h0, e1}, "output after overflow");
    @(posedge pclk);
    chk({31'h0, osc_out}, {31'h0, e2}, "output one cycle later");
  endtask

  task automatic pins(input logic e_out, input logic e_run);
    chk({30'h0, osc_out, osc_run}, {30'h0, e_out, e_run}, "output and run");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    overflow = 1'b0;
    num_errors = 0;
    checks_done = 0;
    tick(16);
    presetn <= 1'b1;
    tick(1);
    pins(1'b0, 1'b0);
    rd_chk(12'h000, 32'h0000_0000, 1'b0);
    apb(1'b1, 12'h000, 32'hffff_ffff, 4'hf);
    rd_chk(12'h000, 32'h0000_00b1, 1'b0);
    pins(1'b1, 1'b1);
    pulse(1'b0, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_0001, 4'h0);
    rd_chk(12'h000, 32'h0000_00b1, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0081, 4'h1);
    pins(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0000, 4'h1);
    pins(1'b0, 1'b0);
    pulse(1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0080, 4'h1);
    pulse(1'b1, 1'b1);
    rd_chk(12'h000, 32'h0000_00a0, 1'b0);
    pulse(1'b0, 1'b0);
    apb(1'b1, 12'h000, 32'h0000_0090, 4'h1);
    pins(1'b1, 1'b1);
    pulse(1'b0, 1'b0);
    apb(1'b1, 12'h004, 32'h0000_0000, 4'hf);
    chk({31'h0, err}, 32'h0000_0001, "unmapped write error");
    rd_chk(12'h004, 32'h0000_0000, 1'b1);
    rd_chk(12'h000, 32'h0000_0090, 1'b0);
    presetn <= 1'b0;
    tick(2);
    pins(1'b0, 1'b0);
    presetn <= 1'b1;
    tick(1);
    rd_chk(12'h000, 32'h0000_0000, 1'b0);
    results();
  end
endmodule
